/* src/tdpr_defines.svh */
`ifndef TDPR_DEFINES_SVH
`define TDPR_DEFINES_SVH

// storage geometry
`define TDPR_DATA_BITS      16384
`define TDPR_PAR_BITS       2048
`define TDPR_DATA_ADDR_W    14
`define TDPR_PAR_ADDR_W     11
`define TDPR_BUS_DATA_W     32
`define TDPR_BUS_PAR_W      4

// register byte offsets (low address byte only)
`define TDPR_OFS_CFG        8'h00
`define TDPR_OFS_SETVAL_A   8'h04
`define TDPR_OFS_SETVAL_B   8'h08
`define TDPR_OFS_SETPAR     8'h0C
`define TDPR_OFS_STATUS     8'h10
`define TDPR_OFS_INFO       8'h14

// field positions
`define TDPR_CFG_MODEA_LSB  0
`define TDPR_CFG_MODEB_LSB  2
`define TDPR_SETPAR_B_LSB   4
`define TDPR_STS_WW_BIT     0
`define TDPR_STS_RW_BIT     1
`define TDPR_INFO_WB_LSB    8

// mode field codes
`define TDPR_MODE_WF        2'h0
`define TDPR_MODE_RF        2'h1
`define TDPR_MODE_NC        2'h2

// reset values
`define TDPR_SETVAL_RESET   32'h0000_0000
`define TDPR_SETPAR_RESET   8'h00
`define TDPR_DOUT_RESET     36'h0_0000_0000

`endif

/* src/tdpr_pkg.sv */
package tdpr_pkg;

   // read-during-write behaviour of one port
   typedef enum logic [1:0] {
      TDPR_WRITE_FIRST,
      TDPR_READ_FIRST,
      TDPR_NO_CHANGE
   } tdpr_mode_t;

   // one port's request from user logic
   typedef struct packed {
      logic        en;              // port enable
      logic        we;              // write enable
      logic        syncOutputSet;   // synchronous output set
      logic [13:0] addr;            // low bits used per width
      logic [31:0] writeDataBus;    // data in, low bits used
      logic [3:0]  writeParityBus;  // parity in, low bits used
   } tdpr_port_req_t;

   // one port's registered output
   typedef struct packed {
      logic [31:0] readDataBus;
      logic [3:0]  readParityBus;
   } tdpr_port_resp_t;

endpackage : tdpr_pkg

/* src/tdpr_port_out.sv */
`timescale 1ns/1ps
`include "tdpr_defines.svh"

module tdpr_port_out
   import tdpr_pkg::*;
#(
   parameter int DW = 32,                    // data bits of this port
   parameter int PW = 4                      // parity bits of this port
) (
   input  wire logic            clk_sys,
   input  wire logic            resetn,
   input  wire tdpr_port_req_t  req,         // this port's request
   input  wire logic            portOn,      // port present
   input  tdpr_mode_t           mode,        // read-during-write mode
   input  wire logic [31:0]     setData,     // output set value, data
   input  wire logic [3:0]      setPar,      // output set value, parity
   input  wire logic [31:0]     oldData,     // addressed word before write
   input  wire logic [3:0]      oldPar,      // addressed parity before write
   input  wire logic [31:0]     invData,     // bits spoiled by a collision
   input  wire logic [3:0]      invPar,      // parity bits spoiled
   output tdpr_port_resp_t      resp
);

   tdpr_port_resp_t portOut_reg;             // output latches
   tdpr_port_resp_t readVal;                 // masked read result
   tdpr_port_resp_t writeVal;                // masked input word
   tdpr_port_resp_t oldVal;                  // masked prior contents
   tdpr_port_resp_t setVal;                  // masked set value

   // mask every path to the port width, spoil collided bits
   always_comb begin
      readVal  = '0;
      writeVal = '0;
      oldVal   = '0;
      setVal   = '0;
      for (int i = 0; i < DW; i++) begin
         readVal.readDataBus[i]  = invData[i] ? 1'bx : oldData[i];
         writeVal.readDataBus[i] = req.writeDataBus[i];
         oldVal.readDataBus[i]   = oldData[i];
         setVal.readDataBus[i]   = setData[i];
      end
      for (int j = 0; j < PW; j++) begin
         readVal.readParityBus[j]  = invPar[j] ? 1'bx : oldPar[j];
         writeVal.readParityBus[j] = req.writeParityBus[j];
         oldVal.readParityBus[j]   = oldPar[j];
         setVal.readParityBus[j]   = setPar[j];
      end
   end

   // output latch update
   // holds between operations
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         portOut_reg <= `TDPR_DOUT_RESET;
      end else if (portOn && req.en) begin
         if (req.syncOutputSet) begin
            portOut_reg <= setVal;
         end else if (!req.we) begin
            portOut_reg <= readVal;
         end else begin
            case (mode)
               TDPR_WRITE_FIRST: portOut_reg <= writeVal;
               TDPR_READ_FIRST:  portOut_reg <= oldVal;
               default:          portOut_reg <= portOut_reg;
            endcase
         end
      end
   end

   assign resp = portOut_reg;

endmodule : tdpr_port_out

/* src/tdpr_true_dual_port_ram.sv */
// Contract
// - one array, two interchangeable ports
// - per-port enable, write enable, clocked
// - read loads output register at edge
// - write stores data at edge
// - transparent write echoes input word
// - read-first shows old word
// - no-change keeps output register
// - mode per port, default transparent
// - only overlapping bits invalid
// - dual same-cell reads agree
// - differing dual writes spoil cell
// - write wins, writer follows mode
// - reader old if read-first, else invalid
// - no combinational address-to-output path
// - output holds until next operation
// - parity stored like data bits
// - widths 1..36, single-port variant
// - disabled port does nothing
// - enabled non-write is read
// - output set loads configured value
// - address width follows port width
`timescale 1ns/1ps
`include "tdpr_defines.svh"

module tdpr_true_dual_port_ram
   import tdpr_pkg::*;
#(
   parameter int WIDTH_A = 36,               // 1,2,4,9,18 or 36
   parameter int WIDTH_B = 36,               // 1,2,4,9,18 or 36
   parameter bit DUAL    = 1'b1              // 0 gives single-port use
) (
   input  wire logic            clk_sys,
   input  wire logic            resetn,
   input  wire logic            hsel,
   input  wire logic [31:0]     haddr,
   input  wire logic [1:0]      htrans,
   input  wire logic            hwrite,
   input  wire logic [2:0]      hsize,
   input  wire logic [31:0]     hwdata,
   input  wire logic            hready,
   output logic                 hreadyout,
   output logic                 hresp,
   output logic [31:0]          hrdata,
   input  wire tdpr_port_req_t  portAReq,
   output tdpr_port_resp_t      portAResp,
   input  wire tdpr_port_req_t  portBReq,
   output tdpr_port_resp_t      portBResp
);

   localparam int DWA = (WIDTH_A >= 9) ? (WIDTH_A * 8) / 9 : WIDTH_A;
   localparam int PWA = (WIDTH_A >= 9) ? WIDTH_A / 9 : 0;
   localparam int DWB = (WIDTH_B >= 9) ? (WIDTH_B * 8) / 9 : WIDTH_B;
   localparam int PWB = (WIDTH_B >= 9) ? WIDTH_B / 9 : 0;
   localparam int SHA = $clog2(DWA);
   localparam int SHB = $clog2(DWB);
   localparam int PSA = (PWA > 0) ? $clog2(PWA) : 0;
   localparam int PSB = (PWB > 0) ? $clog2(PWB) : 0;
   localparam int SHM = (SHA > SHB) ? SHA : SHB;

   logic                        dataMem [0:`TDPR_DATA_BITS-1];  // data cells
   logic                        parMem  [0:`TDPR_PAR_BITS-1];   // parity cells
   logic [13:0]                 baseA;       // first data bit of port A word
   logic [13:0]                 baseB;       // first data bit of port B word
   logic [10:0]                 pBaseA;      // first parity bit, port A
   logic [10:0]                 pBaseB;      // first parity bit, port B
   logic                        enA;         // port A active
   logic                        enB;         // port B active
   logic                        wrA;         // port A writes
   logic                        wrB;         // port B writes
   logic                        rdA;         // port A reads
   logic                        rdB;         // port B reads
   logic                        overlap;     // words share cells
   logic [31:0]                 oldDataA;    // contents before this edge
   logic [31:0]                 oldDataB;
   logic [3:0]                  oldParA;
   logic [3:0]                  oldParB;
   logic [31:0]                 invDataA;    // spoiled output bits
   logic [31:0]                 invDataB;
   logic [3:0]                  invParA;
   logic [3:0]                  invParB;
   logic [31:0]                 clashDataB;  // B bits differing from A write
   logic [3:0]                  clashParB;
   logic                        wwHit;       // same-cell dual write
   logic                        rwHit;       // reader spoiled by writer
   tdpr_mode_t                  modeA_reg;   // port A read-during-write
   tdpr_mode_t                  modeB_reg;   // port B read-during-write
   logic [31:0]                 setValA_reg; // output set data, port A
   logic [31:0]                 setValB_reg; // output set data, port B
   logic [7:0]                  setPar_reg;  // output set parity, both ports
   logic                        wwFlag_reg;  // sticky dual-write seen
   logic                        rwFlag_reg;  // sticky spoiled read seen
   logic                        wwFlag_next;
   logic                        rwFlag_next;
   logic                        wrPend_reg;  // write data phase pending
   logic [7:0]                  wrAddr_reg;  // address of pending write
   logic [31:0]                 hrdata_reg;  // read data phase value
   logic [31:0]                 rdValue;     // register read mux
   logic                        rdTake;      // read address phase taken
   logic                        wrTake;      // write address phase taken

   assign enA = portAReq.en;
   assign enB = DUAL & portBReq.en;
   assign wrA = enA & portAReq.we;
   assign wrB = enB & portBReq.we;
   assign rdA = enA & ~portAReq.we;
   assign rdB = enB & ~portBReq.we;

   // address truncated by shift to width
   assign baseA  = portAReq.addr << SHA;
   assign baseB  = portBReq.addr << SHB;
   assign pBaseA = 11'(portAReq.addr << PSA);
   assign pBaseB = 11'(portBReq.addr << PSB);

   // aligned words overlap when equal at the coarser grain
   assign overlap = ((baseA >> SHM) == (baseB >> SHM));

   // addressed contents and collision masks
   always_comb begin
      oldDataA   = '0;
      oldDataB   = '0;
      oldParA    = '0;
      oldParB    = '0;
      invDataA   = '0;
      invDataB   = '0;
      invParA    = '0;
      invParB    = '0;
      clashDataB = '0;
      clashParB  = '0;
      for (int i = 0; i < DWA; i++) begin
         oldDataA[i] = dataMem[14'(baseA + 14'(i))];
         invDataA[i] = rdA & wrB & (modeB_reg != TDPR_READ_FIRST)
                     & ((14'(baseA + 14'(i)) >> SHB) == (baseB >> SHB));
      end
      for (int i = 0; i < DWB; i++) begin
         oldDataB[i] = dataMem[14'(baseB + 14'(i))];
         invDataB[i] = rdB & wrA & (modeA_reg != TDPR_READ_FIRST)
                     & ((14'(baseB + 14'(i)) >> SHA) == (baseA >> SHA));
         // differing bits of a dual write
         clashDataB[i] = wrA & ((14'(baseB + 14'(i)) >> SHA) == (baseA >> SHA))
                       & (portAReq.writeDataBus[5'(14'(baseB + 14'(i)) - baseA)]
                          != portBReq.writeDataBus[i]);
      end
      // parity cells follow the same rules
      for (int j = 0; j < PWA; j++) begin
         oldParA[j] = parMem[11'(pBaseA + 11'(j))];
         invParA[j] = (PWB > 0) & rdA & wrB & (modeB_reg != TDPR_READ_FIRST)
                    & ((11'(pBaseA + 11'(j)) >> PSB) == (pBaseB >> PSB));
      end
      for (int j = 0; j < PWB; j++) begin
         oldParB[j]  = parMem[11'(pBaseB + 11'(j))];
         invParB[j]  = (PWA > 0) & rdB & wrA & (modeA_reg != TDPR_READ_FIRST)
                     & ((11'(pBaseB + 11'(j)) >> PSA) == (pBaseA >> PSA));
         clashParB[j] = (PWA > 0) & wrA
                      & ((11'(pBaseB + 11'(j)) >> PSA) == (pBaseA >> PSA))
                      & (portAReq.writeParityBus[2'(11'(pBaseB + 11'(j)) - pBaseA)]
                         != portBReq.writeParityBus[j]);
      end
   end

   // cell update; B after A so a clash overrides both
   always_ff @(posedge clk_sys) begin
      if (wrA) begin
         for (int i = 0; i < DWA; i++) begin
            dataMem[14'(baseA + 14'(i))] <= portAReq.writeDataBus[i];
         end
         for (int j = 0; j < PWA; j++) begin
            parMem[11'(pBaseA + 11'(j))] <= portAReq.writeParityBus[j];
         end
      end
      if (wrB) begin
         for (int i = 0; i < DWB; i++) begin
            dataMem[14'(baseB + 14'(i))] <= clashDataB[i] ? 1'bx : portBReq.writeDataBus[i];
         end
         for (int j = 0; j < PWB; j++) begin
            parMem[11'(pBaseB + 11'(j))] <= clashParB[j] ? 1'bx : portBReq.writeParityBus[j];
         end
      end
   end

   // reads share one array, identical data
   // port A output latches
   tdpr_port_out #(
      .DW (DWA),
      .PW (PWA)
   ) u_outA (
      .clk_sys (clk_sys),
      .resetn  (resetn),
      .req     (portAReq),
      .portOn  (1'b1),
      .mode    (modeA_reg),
      .setData (setValA_reg),
      .setPar  (setPar_reg[3:0]),
      .oldData (oldDataA),
      .oldPar  (oldParA),
      .invData (invDataA),
      .invPar  (invParA),
      .resp    (portAResp)
   );

   // port B output latches
   tdpr_port_out #(
      .DW (DWB),
      .PW (PWB)
   ) u_outB (
      .clk_sys (clk_sys),
      .resetn  (resetn),
      .req     (portBReq),
      .portOn  (DUAL),
      .mode    (modeB_reg),
      .setData (setValB_reg),
      .setPar  (setPar_reg[7:4]),
      .oldData (oldDataB),
      .oldPar  (oldParB),
      .invData (invDataB),
      .invPar  (invParB),
      .resp    (portBResp)
   );

   assign wwHit = wrA & wrB & overlap;
   assign rwHit = |{invDataA, invDataB, invParA, invParB};

   // ahb address phase qualification
   assign rdTake = hsel & hready & htrans[1] & ~hwrite;
   assign wrTake = hsel & hready & htrans[1] & hwrite;

   // register read mux on the address phase
   always_comb begin
      rdValue = 32'h0000_0000;
      if (haddr[7:0] == `TDPR_OFS_CFG) begin
         rdValue[`TDPR_CFG_MODEA_LSB +: 2] = modeA_reg;
         rdValue[`TDPR_CFG_MODEB_LSB +: 2] = modeB_reg;
      end else if (haddr[7:0] == `TDPR_OFS_SETVAL_A) begin
         rdValue = setValA_reg;
      end else if (haddr[7:0] == `TDPR_OFS_SETVAL_B) begin
         rdValue = setValB_reg;
      end else if (haddr[7:0] == `TDPR_OFS_SETPAR) begin
         rdValue[7:0] = setPar_reg;
      end else if (haddr[7:0] == `TDPR_OFS_STATUS) begin
         rdValue[`TDPR_STS_WW_BIT] = wwFlag_reg;
         rdValue[`TDPR_STS_RW_BIT] = rwFlag_reg;
      end else if (haddr[7:0] == `TDPR_OFS_INFO) begin
         rdValue[5:0] = 6'(WIDTH_A);
         rdValue[`TDPR_INFO_WB_LSB +: 6] = DUAL ? 6'(WIDTH_B) : 6'h00;
      end
   end

   // ahb address phase capture and read data
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         wrPend_reg <= 1'b0;
         wrAddr_reg <= 8'h00;
         hrdata_reg <= 32'h0000_0000;
      end else begin
         if (hready) begin
            wrPend_reg <= wrTake;
            wrAddr_reg <= haddr[7:0];
         end
         if (rdTake) begin
            hrdata_reg <= rdValue;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         modeA_reg <= TDPR_WRITE_FIRST;
         modeB_reg <= TDPR_WRITE_FIRST;
      end else if (wrPend_reg && (wrAddr_reg == `TDPR_OFS_CFG)) begin
         case (hwdata[`TDPR_CFG_MODEA_LSB +: 2])
            `TDPR_MODE_RF: modeA_reg <= TDPR_READ_FIRST;
            `TDPR_MODE_NC: modeA_reg <= TDPR_NO_CHANGE;
            default:       modeA_reg <= TDPR_WRITE_FIRST;
         endcase
         case (hwdata[`TDPR_CFG_MODEB_LSB +: 2])
            `TDPR_MODE_RF: modeB_reg <= TDPR_READ_FIRST;
            `TDPR_MODE_NC: modeB_reg <= TDPR_NO_CHANGE;
            default:       modeB_reg <= TDPR_WRITE_FIRST;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         setValA_reg <= `TDPR_SETVAL_RESET;
         setValB_reg <= `TDPR_SETVAL_RESET;
         setPar_reg  <= `TDPR_SETPAR_RESET;
      end else if (wrPend_reg) begin
         if (wrAddr_reg == `TDPR_OFS_SETVAL_A) begin
            setValA_reg <= hwdata;
         end else if (wrAddr_reg == `TDPR_OFS_SETVAL_B) begin
            setValB_reg <= hwdata;
         end else if (wrAddr_reg == `TDPR_OFS_SETPAR) begin
            setPar_reg <= hwdata[7:0];
         end
      end
   end

   // sticky collision flags, write one to clear, set wins
   always_comb begin
      wwFlag_next = wwFlag_reg;
      rwFlag_next = rwFlag_reg;
      if (wrPend_reg && (wrAddr_reg == `TDPR_OFS_STATUS)) begin
         wwFlag_next = wwFlag_reg & ~hwdata[`TDPR_STS_WW_BIT];
         rwFlag_next = rwFlag_reg & ~hwdata[`TDPR_STS_RW_BIT];
      end
      wwFlag_next = wwFlag_next | wwHit;
      rwFlag_next = rwFlag_next | rwHit;
   end

   // flag registers
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         wwFlag_reg <= 1'b0;
         rwFlag_reg <= 1'b0;
      end else begin
         wwFlag_reg <= wwFlag_next;
         rwFlag_reg <= rwFlag_next;
      end
   end

   // zero-wait slave, always okay
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_reg;

endmodule : tdpr_true_dual_port_ram

/* testbench/tdpr_true_dual_port_ram_sva.sv */
`timescale 1ns/1ps
module tdpr_true_dual_port_ram_sva
   import tdpr_pkg::*;
#(
   parameter int WIDTH_A = 36,
   parameter int WIDTH_B = 36
) (
   input wire logic            clk_sys,
   input wire logic            resetn,
   input wire logic            hsel,
   input wire logic [31:0]     haddr,
   input wire logic [1:0]      htrans,
   input wire logic            hwrite,
   input wire logic [31:0]     hwdata,
   input wire logic            hready,
   input wire logic            hreadyout,
   input wire logic            hresp,
   input wire tdpr_port_req_t  portAReq,
   input wire tdpr_port_resp_t portAResp,
   input wire tdpr_port_req_t  portBReq,
   input wire tdpr_port_resp_t portBResp
);
   localparam int DWB  = (WIDTH_B < 9) ? WIDTH_B : 8 * WIDTH_B / 9; // port b data bits
   localparam bit PAIR = (WIDTH_A == 36) && (WIDTH_B == 18);        // mapping below fits
   logic       cfgPend_reg;  // cfg write in data phase
   logic [1:0] modeA_reg;    // shadow of port a mode
   // shadow the port a mode from bus writes
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         cfgPend_reg <= 1'b0;
         modeA_reg   <= 2'h0;
      end else begin
         cfgPend_reg <= hsel && hready && htrans[1] && hwrite && (haddr[7:0] == 8'h00);
         if (cfgPend_reg) begin
            modeA_reg <= hwdata[1:0];
         end
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   // plain write on port a
   sequence s_a_write;
      portAReq.en && portAReq.we && !portAReq.syncOutputSet;
   endsequence
   // both ports read the same cells
   sequence s_dual_read;
      portAReq.en && !portAReq.we && !portAReq.syncOutputSet && portBReq.en && !portBReq.we
         && !portBReq.syncOutputSet && (portBReq.addr[9:0] == {portAReq.addr[8:0], 1'b0});
   endsequence
   chk_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus answer not zero-wait okay");
   chk_a_idle_holds: assert property (!portAReq.en |=> portAResp === $past(portAResp))
      else $error("port a output moved while disabled");
   chk_b_idle_holds: assert property (!portBReq.en |=> portBResp === $past(portBResp))
      else $error("port b output moved while disabled");
   chk_a_clocked_only: assert property (portAResp !== $past(portAResp) |-> $past(portAReq.en))
      else $error("port a output changed without an operation");
   chk_b_upper_zero: assert property ((portBResp.readDataBus >> DWB) == 32'h0000_0000)
      else $error("port b data above width not zero");
   chk_dual_read_agree: assert property ((PAIR and s_dual_read) |=>
      portBResp.readDataBus[15:0] === portAResp.readDataBus[15:0]
      && portBResp.readParityBus[1:0] === portAResp.readParityBus[1:0])
      else $error("dual read of one cell disagrees");
   chk_write_first: assert property (s_a_write ##0 (modeA_reg != 2'h1 && modeA_reg != 2'h2) |=>
      portAResp === {$past(portAReq.writeDataBus), $past(portAReq.writeParityBus)})
      else $error("transparent write did not echo input");
   chk_no_change: assert property (s_a_write ##0 modeA_reg == 2'h2 |=> portAResp === $past(portAResp))
      else $error("no-change write altered output");
endmodule : tdpr_true_dual_port_ram_sva

bind tdpr_true_dual_port_ram tdpr_true_dual_port_ram_sva #(.WIDTH_A(WIDTH_A), .WIDTH_B(WIDTH_B)) u_sva (
   .clk_sys(clk_sys), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .portAReq(portAReq),
   .portAResp(portAResp), .portBReq(portBReq), .portBResp(portBResp));

/* testbench/tdpr_user_port.sv */
`timescale 1ns/1ps
module tdpr_user_port
   import tdpr_pkg::*;
(
   input  wire logic            clk_sys,
   output tdpr_port_req_t       req,
   input  wire tdpr_port_resp_t resp
);
   // idle port at time zero
   initial begin
      req = '0;
   end
   // one operation, then an idle cycle, then sample
   task automatic issue(input logic we, input logic set, input logic [13:0] a, input logic [31:0] d,
                        input logic [3:0] p, output tdpr_port_resp_t r);
      @(posedge clk_sys);
      req <= '{en: 1'b1, we: we, syncOutputSet: set, addr: a, writeDataBus: d, writeParityBus: p};
      @(posedge clk_sys);
      req <= '{en: 1'b0, we: ~we, syncOutputSet: 1'b1, addr: ~a, writeDataBus: ~d, writeParityBus: ~p};
      @(posedge clk_sys);
      r = resp;
   endtask : issue
endmodule : tdpr_user_port

/* testbench/tb_true_dual_port_block_ram.sv */
`timescale 1ns/1ps
module tb_true_dual_port_block_ram
   import tdpr_pkg::*;
;
   logic            clk_sys, resetn, hsel, hwrite, hreadyout, hresp;
   logic [31:0]     haddr, hwdata, hrdata, rd;
   logic [1:0]      htrans;
   logic [2:0]      hsize;
   tdpr_port_req_t  portAReq, portBReq;
   tdpr_port_resp_t portAResp, portBResp, ra, rb;
   int              err_count, n_compared;
   tdpr_true_dual_port_ram #(.WIDTH_A(36), .WIDTH_B(18), .DUAL(1'b1)) dut (
      .clk_sys(clk_sys), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .portAReq(portAReq), .portAResp(portAResp), .portBReq(portBReq),
      .portBResp(portBResp));
   tdpr_user_port uA (.clk_sys(clk_sys), .req(portAReq), .resp(portAResp));
   tdpr_user_port uB (.clk_sys(clk_sys), .req(portBReq), .resp(portBResp));
   // compare and count
   task check(input string name, input logic [35:0] seen, input logic [35:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   // one ahb-lite single word transfer
   task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : ahb
   task reg_rd(input logic [31:0] a, input logic [31:0] exp);
      ahb(1'b0, a, 32'h0000_0000);
      check("hrdata", {4'h0, rd}, {4'h0, exp});
   endtask : reg_rd
   // verdict
   task report_and_stop();
      $display("compares %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : report_and_stop
   // free-running clock
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   // watchdog
   initial begin
      #20000;
      err_count++;
      report_and_stop();
   end
   // main sequence
   initial begin
      resetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
      hsize = 3'h2; hwdata = 32'h0; err_count = 0; n_compared = 0;
      repeat (2) @(posedge clk_sys);
      resetn <= 1'b1;
      reg_rd(32'h0000_0000, 32'h0000_0000);
      reg_rd(32'h0000_0004, 32'h0000_0000);
      reg_rd(32'h0000_0014, 32'h0000_1224);
      reg_rd(32'h0000_0020, 32'h0000_0000);
      uA.issue(1'b1, 1'b0, 14'h0005, 32'hA5A5_1234, 4'h9, ra);
      check("portA", ra, {32'hA5A5_1234, 4'h9});
      uA.issue(1'b0, 1'b0, 14'h0005, 32'h0, 4'h0, ra);
      check("portA", ra, {32'hA5A5_1234, 4'h9});
      uB.issue(1'b0, 1'b0, 14'h000A, 32'h0, 4'h0, rb);
      check("portB", rb, {32'h0000_1234, 4'h1});
      uB.issue(1'b0, 1'b0, 14'h000B, 32'h0, 4'h0, rb);
      check("portB", rb, {32'h0000_A5A5, 4'h2});
      uB.issue(1'b1, 1'b0, 14'h000A, 32'h0000_BEEF, 4'h3, rb);
      check("portB", rb, {32'h0000_BEEF, 4'h3});
      uA.issue(1'b0, 1'b0, 14'h0005, 32'h0, 4'h0, ra);
      check("portA", ra, {32'hA5A5_BEEF, 4'hB});
      ahb(1'b1, 32'h0000_0000, 32'h0000_0001);
      reg_rd(32'h0000_0000, 32'h0000_0001);
      uA.issue(1'b1, 1'b0, 14'h0005, 32'h0F0F_0F0F, 4'h6, ra);
      check("portA", ra, {32'hA5A5_BEEF, 4'hB});
      ahb(1'b1, 32'h0000_0000, 32'h0000_0002);
      uA.issue(1'b0, 1'b0, 14'h0005, 32'h0, 4'h0, ra);
      uA.issue(1'b1, 1'b0, 14'h0005, 32'h1111_2222, 4'h1, ra);
      check("portA", ra, {32'h0F0F_0F0F, 4'h6});
      uA.issue(1'b0, 1'b0, 14'h0005, 32'h0, 4'h0, ra);
      check("portA", ra, {32'h1111_2222, 4'h1});
      ahb(1'b1, 32'h0000_0004, 32'hCAFE_F00D);
      ahb(1'b1, 32'h0000_0008, 32'h1234_5678);
      ahb(1'b1, 32'h0000_000C, 32'h0000_002C);
      uA.issue(1'b1, 1'b1, 14'h0005, 32'h3333_4444, 4'h0, ra);
      check("portA", ra, {32'hCAFE_F00D, 4'hC});
      uB.issue(1'b0, 1'b1, 14'h000A, 32'h0, 4'h0, rb);
      check("portB", rb, {32'h0000_5678, 4'h2});
      fork
         uA.issue(1'b0, 1'b0, 14'h0005, 32'h0, 4'h0, ra);
         uB.issue(1'b0, 1'b0, 14'h000A, 32'h0, 4'h0, rb);
      join
      check("portA", ra, {32'h3333_4444, 4'h0});
      check("portB", rb, {32'h0000_4444, 4'h0});
      ahb(1'b1, 32'h0000_0000, 32'h0000_0001);
      fork
         uA.issue(1'b1, 1'b0, 14'h0005, 32'h5555_6666, 4'hF, ra);
         uB.issue(1'b0, 1'b0, 14'h000A, 32'h0, 4'h0, rb);
      join
      check("portA", ra, {32'h3333_4444, 4'h0});
      check("portB", rb, {32'h0000_4444, 4'h0});
      uA.issue(1'b0, 1'b0, 14'h0005, 32'h0, 4'h0, ra);
      check("portA", ra, {32'h5555_6666, 4'hF});
      ahb(1'b1, 32'h0000_0000, 32'h0000_0000);
      fork
         uA.issue(1'b1, 1'b0, 14'h0005, 32'h7777_8888, 4'h0, ra);
         uB.issue(1'b0, 1'b0, 14'h000A, 32'h0, 4'h0, rb);
      join
      check("portB", rb, {16'h0000, 16'hXXXX, 2'h0, 2'hX});
      reg_rd(32'h0000_0010, 32'h0000_0002);
      ahb(1'b1, 32'h0000_0010, 32'h0000_0002);
      reg_rd(32'h0000_0010, 32'h0000_0000);
      fork
         uA.issue(1'b1, 1'b0, 14'h0005, 32'h0000_4444, 4'h0, ra);
         uB.issue(1'b1, 1'b0, 14'h000A, 32'h0000_4444, 4'h0, rb);
      join
      reg_rd(32'h0000_0010, 32'h0000_0001);
      uB.issue(1'b0, 1'b0, 14'h000B, 32'h0, 4'h0, rb);
      check("portB", rb, {32'h0000_0000, 4'h0});
      uB.issue(1'b0, 1'b0, 14'h000A, 32'h0, 4'h0, rb);
      check("portB", rb, {32'h0000_4444, 4'h0});
      ahb(1'b1, 32'h0000_0000, 32'h0000_0007);
      reg_rd(32'h0000_0000, 32'h0000_0004);
      fork
         uA.issue(1'b0, 1'b0, 14'h0005, 32'h0, 4'h0, ra);
         uB.issue(1'b1, 1'b0, 14'h000B, 32'h0000_9999, 4'h3, rb);
      join
      check("portA", ra, {32'h0000_4444, 4'h0});
      check("portB", rb, {32'h0000_0000, 4'h0});
      uA.issue(1'b0, 1'b0, 14'h0005, 32'h0, 4'h0, ra);
      check("portA", ra, {32'h9999_4444, 4'hC});
      reg_rd(32'h0000_0010, 32'h0000_0001);
      report_and_stop();
   end
endmodule : tb_true_dual_port_block_ram
